// [shared/dspx_pkg.sv]
// Constants and types of the DSP core pin logic
// How it works
// - Data bus driven except during external reads
// - Direction low while driving, high while input
// - Three-bit select picks one of eight registers
// - Peripheral captures at strobe rise; core at clock
// - Halt high holds program counter and program address
// - Interrupt line rising edge registers request
// - Interrupt vectors at words 0FFF, 0FFE, 0FFD
// - Interrupt 0 served first, interrupt 2 last
// - Program address released while reset low
// - After reset push PC, load vector 0FFC
// - Store select picks fetch source, start 0000
// - Ready sampled on clock; not ready stretches access
// - Branch tests two synchronised inputs
// - User outputs show inverted status bits five, six
// - Internal code ends at 0FFB; vectors above
// - External mode uses vectors FFFC to FFFF; reset still loads vector 0FFC
// - Two data banks of 256 words each
// - Three eight-bit pointers per bank
// - Word access one cycle, only pointer changes
// - Both banks load multiplier inputs together
// - External access one cycle unless ready extends
// - Entry at instruction end, two cycles, pushes PC
// - Inputs mirrored into status bits ten, eleven
package dspx_pkg;
    // Register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_BR_TARGET = 4'h1;
    localparam logic [3:0] REG_BR_TEST = 4'h2;
    localparam logic [3:0] REG_EXT_SEL = 4'h3;
    localparam logic [3:0] REG_EXT_WRITE = 4'h4;
    localparam logic [3:0] REG_EXT_READ = 4'h5;
    localparam logic [3:0] REG_PTR = 4'h6;
    localparam logic [3:0] REG_RAM_DATA = 4'h7;
    localparam logic [3:0] REG_MAC_X = 4'h8;
    localparam logic [3:0] REG_MAC_Y = 4'h9;
    localparam logic [3:0] REG_PC = 4'hA;
    localparam logic [3:0] REG_RETURN = 4'hB;
    // Status register fields
    localparam int SR_WR_W = 10;
    localparam int SR_OUT0_BIT = 5;
    localparam int SR_OUT1_BIT = 6;
    localparam int SR_IE_BIT = 7;
    localparam logic [9:0] SR_RESET = 10'h000;
    localparam int STAT_BUSY_BIT = 3;
    // Pointer register fields
    localparam int PTR_BANK_BIT = 10;
    localparam int PTR_IDX_LSB = 8;
    localparam logic [1:0] PTR_IDX_MAX = 2'h2;
    localparam int PTRS_PER_BANK = 3;
    localparam int BANK_WORDS = 256;
    localparam int BANKS = 2;
    // Program space
    localparam logic [15:0] PROG_START = 16'h0000;
    localparam logic [15:0] ROM_LAST_CODE = 16'h0FFB;
    localparam logic [15:0] VEC_BASE_INT = 16'h0FFC;
    localparam logic [15:0] VEC_BASE_EXT = 16'hFFFC;
    localparam logic [1:0] VEC_OFF_RESET = 2'h0;
    localparam logic [1:0] VEC_OFF_IRQ0 = 2'h3;
    localparam logic [1:0] VEC_OFF_IRQ1 = 2'h2;
    localparam logic [1:0] VEC_OFF_IRQ2 = 2'h1;
    localparam int STACK_DEPTH = 6;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef enum logic [1:0] {CS_PUSH, CS_VEC, CS_RUN} dspx_core_e;
    typedef enum logic [0:0] {EX_IDLE, EX_BUSY} dspx_ext_e;

    // Vector address in the active space
    function automatic logic [15:0] vec_addr(input logic [1:0] off, input logic ext);
        vec_addr = (ext ? VEC_BASE_EXT : VEC_BASE_INT) | {14'h0000, off};
    endfunction
endpackage

// [shared/dspx_ram_if.sv]
// Pin logic to data RAM signals
`timescale 1ns/1ps
`default_nettype none
interface dspx_ram_if;
    logic ptr_we;
    logic ptr_bank;
    logic [1:0] ptr_idx;
    logic [7:0] ptr_wdata;
    logic [7:0] ptr_rdata;
    logic word_en;
    logic word_we;
    logic [15:0] word_wdata;
    logic [15:0] word_rdata;
    logic dual_en;
    logic [15:0] dual_x;
    logic [15:0] dual_y;
    modport core (output ptr_we, ptr_bank, ptr_idx, ptr_wdata, word_en, word_we, word_wdata, dual_en,
                  input ptr_rdata, word_rdata, dual_x, dual_y);
    modport store (input ptr_we, ptr_bank, ptr_idx, ptr_wdata, word_en, word_we, word_wdata, dual_en,
                   output ptr_rdata, word_rdata, dual_x, dual_y);
endinterface
`default_nettype wire

// [design/dspx_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dspx_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Pins
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // dspx_sync
`default_nettype wire

// [design/dspx_data_ram.sv]
// Two data RAM banks and their pointers
`timescale 1ns/1ps
`default_nettype none
module dspx_data_ram
    import dspx_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Access from the core
    dspx_ram_if.store ram
);
    logic [7:0] ptr_q [BANKS][PTRS_PER_BANK];
    logic [7:0] ptr_d [BANKS][PTRS_PER_BANK];
    logic [15:0] mem_q [BANKS][BANK_WORDS];

    always_comb begin
        ptr_d = ptr_q;
        if (ram.ptr_we) begin
            ptr_d[ram.ptr_bank][ram.ptr_idx] = ram.ptr_wdata;
        end
        if (ram.word_en) begin
            ptr_d[ram.ptr_bank][ram.ptr_idx] = ptr_q[ram.ptr_bank][ram.ptr_idx] + 8'h01;
        end
        if (ram.dual_en) begin
            ptr_d[0][0] = ptr_q[0][0] + 8'h01;
            ptr_d[1][0] = ptr_q[1][0] + 8'h01;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ptr_q <= '{default: '{default: 8'h00}};
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // Bank zero holds words 0-255, bank one words 256-511
    always_ff @(posedge i_clock) begin
        if (ram.word_en && ram.word_we) begin
            mem_q[ram.ptr_bank][ptr_q[ram.ptr_bank][ram.ptr_idx]] <= ram.word_wdata;
        end
    end

    assign ram.ptr_rdata = ptr_q[ram.ptr_bank][ram.ptr_idx];
    assign ram.word_rdata = mem_q[ram.ptr_bank][ptr_q[ram.ptr_bank][ram.ptr_idx]];
    assign ram.dual_x = mem_q[0][ptr_q[0][0]];
    assign ram.dual_y = mem_q[1][ptr_q[1][0]];
endmodule // dspx_data_ram
`default_nettype wire

// [design/dspx_core_pins.sv]
// Pin-side sequencer of the DSP core
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dspx_core_pins
    import dspx_pkg::*;
#(
    parameter logic [15:0] ROM_VEC_RESET = 16'h0000,
    parameter logic [15:0] ROM_VEC_IRQ0 = 16'h0000,
    parameter logic [15:0] ROM_VEC_IRQ1 = 16'h0000,
    parameter logic [15:0] ROM_VEC_IRQ2 = 16'h0000
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Register port
    input wire logic [REG_AW-1:0] i_reg_addr,
    input wire logic [REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [REG_DW-1:0] o_reg_rdata,
    // Peripheral register bus
    output logic [15:0] o_periph_data_bus_out,
    output logic o_periph_data_bus_oe,
    input wire logic [15:0] i_periph_data_bus_in,
    output logic [2:0] o_periph_reg_select,
    output logic o_periph_dir_n,
    output logic o_periph_strobe_n,
    input wire logic i_periph_wait_ready_n,
    // Program memory
    output logic [15:0] o_prog_addr_out,
    output logic o_prog_addr_oe,
    input wire logic [15:0] i_prog_word_in,
    // Control and user pins
    input wire logic [2:0] i_irq_lines,
    input wire logic i_halt,
    input wire logic i_program_store_select_n,
    input wire logic [1:0] i_branch_test_inputs,
    output logic [1:0] o_general_outputs
);
    // Synchronised pins
    logic [7:0] pins_s;
    logic [15:0] pdata_s;
    logic [2:0] irq_s;
    logic halt_s;
    logic ext_fetch_s;
    logic [1:0] branch_s;
    logic ready_n_s;

    dspx_sync #(.W(8)) u_sync_ctrl (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_async({i_irq_lines, i_halt, i_program_store_select_n, i_branch_test_inputs, i_periph_wait_ready_n}),
        .o_sync(pins_s)
    );

    dspx_sync #(.W(16)) u_sync_data (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_async(i_periph_data_bus_in),
        .o_sync(pdata_s)
    );

    assign irq_s = pins_s[7:5];
    assign halt_s = pins_s[4];
    assign ext_fetch_s = pins_s[3];
    assign branch_s = pins_s[2:1];
    assign ready_n_s = pins_s[0];

    dspx_ram_if ram ();

    dspx_data_ram u_ram (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .ram(ram.store)
    );

    // Register strobes decoded
    logic wr_sr;
    logic wr_ext_w;
    logic wr_ext_r;
    logic wr_ptr;
    logic acc_word;
    assign wr_sr = i_reg_wr && (i_reg_addr == REG_STATUS);
    assign wr_ext_w = i_reg_wr && (i_reg_addr == REG_EXT_WRITE);
    assign wr_ext_r = i_reg_wr && (i_reg_addr == REG_EXT_READ);
    assign wr_ptr = i_reg_wr && (i_reg_addr == REG_PTR);
    assign acc_word = (i_reg_wr || i_reg_rd) && (i_reg_addr == REG_RAM_DATA);

    // Core sequencer state
    dspx_core_e state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] addr_q, addr_d;
    logic addr_oe_q, addr_oe_d;
    logic [1:0] vec_off_q, vec_off_d;
    logic [15:0] stack_q [STACK_DEPTH];
    logic [15:0] stack_d [STACK_DEPTH];
    logic [2:0] sp_q, sp_d;
    logic [2:0] irq_prev_q, irq_prev_d;
    logic [2:0] pend_q, pend_d;
    logic [SR_WR_W-1:0] sr_q, sr_d;
    logic [1:0] gen_out_q, gen_out_d;
    logic [15:0] br_target_q, br_target_d;
    logic br_sel_q, br_sel_d;
    logic br_req_q, br_req_d;
    logic ret_req_q, ret_req_d;
    logic [15:0] x_q, x_d;
    logic [15:0] y_q, y_d;
    logic [2:0] ptr_sel_q, ptr_sel_d;
    logic [15:0] rdata_q, rdata_d;

    // External bus state
    dspx_ext_e ext_q, ext_d;
    logic [2:0] esel_q, esel_d;
    logic [15:0] edout_q, edout_d;
    logic edir_n_q, edir_n_d;
    logic eoe_q, eoe_d;
    logic estb_n_q, estb_n_d;
    logic erd_q, erd_d;
    logic [15:0] erdata_q, erdata_d;

    function automatic logic [15:0] rom_word(input logic [1:0] off);
        case (off)
            VEC_OFF_IRQ0: rom_word = ROM_VEC_IRQ0;
            VEC_OFF_IRQ1: rom_word = ROM_VEC_IRQ1;
            VEC_OFF_IRQ2: rom_word = ROM_VEC_IRQ2;
            default: rom_word = ROM_VEC_RESET;
        endcase
    endfunction

    logic [15:0] pc_inc;
    logic stall;
    always_comb begin
        if (!ext_fetch_s && pc_q == ROM_LAST_CODE) begin
            pc_inc = PROG_START;
        end else begin
            pc_inc = pc_q + 16'h0001;
        end
    end
    assign stall = (ext_q == EX_BUSY);

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        addr_d = addr_q;
        addr_oe_d = 1'b1;
        vec_off_d = vec_off_q;
        stack_d = stack_q;
        sp_d = sp_q;
        irq_prev_d = irq_s;
        pend_d = pend_q;
        br_req_d = br_req_q;
        ret_req_d = ret_req_q;
        case (state_q)
            CS_PUSH: begin
                if (sp_q < 3'(STACK_DEPTH)) begin
                    stack_d[sp_q] = pc_q;
                    sp_d = sp_q + 3'h1;
                end else begin
                    stack_d[STACK_DEPTH-1] = pc_q;
                end
                addr_d = vec_addr(vec_off_q, ext_fetch_s);
                state_d = CS_VEC;
            end
            CS_VEC: begin
                pc_d = ext_fetch_s ? i_prog_word_in : rom_word(vec_off_q);
                addr_d = pc_d;
                state_d = CS_RUN;
            end
            CS_RUN: begin
                if (halt_s || stall) begin
                    pc_d = pc_q;
                end else if (sr_q[SR_IE_BIT] && (pend_q != 3'h0)) begin
                    // Lowest line number wins
                    if (pend_q[0]) begin
                        pend_d[0] = 1'b0;
                        vec_off_d = VEC_OFF_IRQ0;
                    end else if (pend_q[1]) begin
                        pend_d[1] = 1'b0;
                        vec_off_d = VEC_OFF_IRQ1;
                    end else begin
                        pend_d[2] = 1'b0;
                        vec_off_d = VEC_OFF_IRQ2;
                    end
                    pc_d = pc_inc;
                    state_d = CS_PUSH;
                end else if (ret_req_q) begin
                    ret_req_d = 1'b0;
                    if (sp_q != 3'h0) begin
                        pc_d = stack_q[sp_q - 3'h1];
                        sp_d = sp_q - 3'h1;
                    end else begin
                        pc_d = pc_inc;
                    end
                end else if (br_req_q) begin
                    br_req_d = 1'b0;
                    pc_d = branch_s[br_sel_q] ? br_target_q : pc_inc;
                end else begin
                    pc_d = pc_inc;
                end
                addr_d = pc_d;
            end
            default: begin
                state_d = CS_PUSH;
            end
        endcase
        // Edges win over clears
        pend_d = pend_d | (irq_s & ~irq_prev_q);
        if (i_reg_wr && i_reg_addr == REG_BR_TEST) begin
            br_req_d = 1'b1;
        end
        if (i_reg_wr && i_reg_addr == REG_RETURN) begin
            ret_req_d = 1'b1;
        end
    end

    // Software-visible registers
    always_comb begin
        sr_d = sr_q;
        br_target_d = br_target_q;
        br_sel_d = br_sel_q;
        ptr_sel_d = ptr_sel_q;
        x_d = x_q;
        y_d = y_q;
        rdata_d = 16'h0000;
        if (wr_sr) begin
            sr_d = i_reg_wdata[SR_WR_W-1:0];
        end
        gen_out_d = ~{sr_d[SR_OUT1_BIT], sr_d[SR_OUT0_BIT]};
        if (i_reg_wr && i_reg_addr == REG_BR_TARGET) begin
            br_target_d = i_reg_wdata;
        end
        if (i_reg_wr && i_reg_addr == REG_BR_TEST) begin
            br_sel_d = i_reg_wdata[0];
        end
        if (wr_ptr) begin
            ptr_sel_d[2] = i_reg_wdata[PTR_BANK_BIT];
            ptr_sel_d[1:0] = (i_reg_wdata[PTR_IDX_LSB+1:PTR_IDX_LSB] > PTR_IDX_MAX) ? PTR_IDX_MAX
                             : i_reg_wdata[PTR_IDX_LSB+1:PTR_IDX_LSB];
        end
        if (i_reg_wr && i_reg_addr == REG_MAC_X) begin
            x_d = ram.dual_x;
            y_d = ram.dual_y;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_STATUS: rdata_d = {4'h0, branch_s, sr_q};
                REG_BR_TARGET: rdata_d = br_target_q;
                REG_EXT_SEL: rdata_d = {13'h0000, esel_q};
                REG_EXT_WRITE: rdata_d = erdata_q;
                REG_EXT_READ: rdata_d = {12'h000, stall, pend_q};
                REG_PTR: rdata_d = {8'h00, ram.ptr_rdata};
                REG_RAM_DATA: rdata_d = ram.word_rdata;
                REG_MAC_X: rdata_d = x_q;
                REG_MAC_Y: rdata_d = y_q;
                REG_PC: rdata_d = pc_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Data RAM requests
    always_comb begin
        ram.ptr_we = wr_ptr;
        ram.ptr_bank = wr_ptr ? i_reg_wdata[PTR_BANK_BIT] : ptr_sel_q[2];
        ram.ptr_idx = wr_ptr ? ptr_sel_d[1:0] : ptr_sel_q[1:0];
        ram.ptr_wdata = i_reg_wdata[7:0];
        ram.word_en = acc_word;
        ram.word_we = i_reg_wr;
        ram.word_wdata = i_reg_wdata;
        ram.dual_en = i_reg_wr && (i_reg_addr == REG_MAC_X);
    end

    // External register bus next state
    always_comb begin
        ext_d = ext_q;
        esel_d = esel_q;
        edout_d = edout_q;
        edir_n_d = edir_n_q;
        estb_n_d = estb_n_q;
        erd_d = erd_q;
        erdata_d = erdata_q;
        case (ext_q)
            EX_IDLE: begin
                if (i_reg_wr && i_reg_addr == REG_EXT_SEL) begin
                    esel_d = i_reg_wdata[2:0];
                end
                if (wr_ext_w) begin
                    edout_d = i_reg_wdata;
                    edir_n_d = 1'b0;
                    estb_n_d = 1'b0;
                    erd_d = 1'b0;
                    ext_d = EX_BUSY;
                end else if (wr_ext_r) begin
                    edir_n_d = 1'b1;
                    estb_n_d = 1'b0;
                    erd_d = 1'b1;
                    ext_d = EX_BUSY;
                end
            end
            EX_BUSY: begin
                if (!ready_n_s) begin
                    // Strobe rise: peripheral capture
                    estb_n_d = 1'b1;
                    edir_n_d = 1'b0;
                    if (erd_q) begin
                        erdata_d = pdata_s;
                    end
                    erd_d = 1'b0;
                    ext_d = EX_IDLE;
                end
            end
            default: begin
                ext_d = EX_IDLE;
            end
        endcase
        eoe_d = ~edir_n_d;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_q <= CS_PUSH;
            pc_q <= PROG_START;
            addr_q <= WORD_RESET;
            addr_oe_q <= 1'b0;
            vec_off_q <= VEC_OFF_RESET;
            stack_q <= '{default: WORD_RESET};
            sp_q <= 3'h0;
            irq_prev_q <= 3'h0;
            pend_q <= 3'h0;
            br_req_q <= 1'b0;
            ret_req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            addr_q <= addr_d;
            addr_oe_q <= addr_oe_d;
            vec_off_q <= vec_off_d;
            stack_q <= stack_d;
            sp_q <= sp_d;
            irq_prev_q <= irq_prev_d;
            pend_q <= pend_d;
            br_req_q <= br_req_d;
            ret_req_q <= ret_req_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            sr_q <= SR_RESET;
            gen_out_q <= 2'h3;
            br_target_q <= WORD_RESET;
            br_sel_q <= 1'b0;
            ptr_sel_q <= SEL_RESET;
            x_q <= WORD_RESET;
            y_q <= WORD_RESET;
            rdata_q <= WORD_RESET;
        end else begin
            sr_q <= sr_d;
            gen_out_q <= gen_out_d;
            br_target_q <= br_target_d;
            br_sel_q <= br_sel_d;
            ptr_sel_q <= ptr_sel_d;
            x_q <= x_d;
            y_q <= y_d;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ext_q <= EX_IDLE;
            esel_q <= SEL_RESET;
            edout_q <= WORD_RESET;
            edir_n_q <= 1'b0;
            eoe_q <= 1'b1;
            estb_n_q <= 1'b1;
            erd_q <= 1'b0;
            erdata_q <= WORD_RESET;
        end else begin
            ext_q <= ext_d;
            esel_q <= esel_d;
            edout_q <= edout_d;
            edir_n_q <= edir_n_d;
            eoe_q <= eoe_d;
            estb_n_q <= estb_n_d;
            erd_q <= erd_d;
            erdata_q <= erdata_d;
        end
    end

    // Outputs
    assign o_reg_rdata = rdata_q;
    assign o_periph_data_bus_out = edout_q;
    assign o_periph_data_bus_oe = eoe_q;
    assign o_periph_reg_select = esel_q;
    assign o_periph_dir_n = edir_n_q;
    assign o_periph_strobe_n = estb_n_q;
    assign o_prog_addr_out = addr_q;
    assign o_prog_addr_oe = addr_oe_q;
    assign o_general_outputs = gen_out_q;
endmodule // dspx_core_pins
`default_nettype wire

// [test/dspx_periph_model.sv]
// Model of program memory and peripheral registers
`timescale 1ns/1ps
`default_nettype none
module dspx_periph_model (
    // Clock
    input wire logic i_clock,
    // Peripheral bus
    input wire logic i_strobe_n,
    input wire logic i_dir_n,
    input wire logic [2:0] i_sel,
    input wire logic [15:0] i_bus,
    input wire logic [3:0] i_wait,
    output logic o_ready_n,
    output logic [15:0] o_drive,
    // Program memory
    input wire logic [15:0] i_prog_addr,
    output logic [15:0] o_prog_word
);
    logic [15:0] regs [8] = '{default: 16'h0000};
    logic [3:0] cnt_q = 4'h0;
    logic wr_q = 1'b0;
    always_ff @(posedge i_clock) cnt_q <= i_strobe_n ? 4'h0 : cnt_q + 4'h1;
    assign o_ready_n = i_wait != 4'h0 && (i_strobe_n || cnt_q < i_wait);
    always @(negedge i_clock) if (!i_strobe_n) wr_q <= !i_dir_n;
    always @(posedge i_strobe_n) if (wr_q) regs[i_sel] <= i_bus;
    assign o_drive = i_dir_n ? regs[i_sel] : ~i_bus;
    assign o_prog_word = (i_prog_addr[15:2] == 14'h3FFF) ? 16'h3000 : ~i_prog_addr;
endmodule // dspx_periph_model
`default_nettype wire

// [test/dspx_core_pins_chk.sv]
// Assertions for the DSP core pin-side sequencer
`timescale 1ns/1ps
`default_nettype none
module dspx_core_pins_chk
    import dspx_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Register port
    input wire logic [REG_AW-1:0] i_reg_addr,
    input wire logic [REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    // Peripheral bus
    input wire logic [15:0] o_periph_data_bus_out,
    input wire logic o_periph_data_bus_oe,
    input wire logic o_periph_dir_n,
    input wire logic o_periph_strobe_n,
    input wire logic i_periph_wait_ready_n,
    // Program and control
    input wire logic [15:0] o_prog_addr_out,
    input wire logic o_prog_addr_oe,
    input wire logic i_halt,
    input wire logic [1:0] o_general_outputs
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    wire logic ext_wr = i_reg_wr && i_reg_addr == REG_EXT_WRITE && o_periph_strobe_n;
    wire logic ext_rd = i_reg_wr && i_reg_addr == REG_EXT_READ && o_periph_strobe_n;
    bus_dir_a: assert property (o_periph_data_bus_oe == !o_periph_dir_n
        && (o_periph_data_bus_oe || !o_periph_strobe_n))
        else $error("Bus release wrong");
    reset_release_a: assert property (disable iff (1'b0) !i_rst_b |=> !o_prog_addr_oe)
        else $error("Address driven in reset");
    reset_vector_a: assert property ($rose(i_rst_b) |=> o_prog_addr_oe && o_prog_addr_out == VEC_BASE_INT)
        else $error("No reset vector");
    out_invert_a: assert property (i_reg_wr && i_reg_addr == REG_STATUS |=>
        o_general_outputs == ~$past(i_reg_wdata[6:5]))
        else $error("Outputs not inverted");
    wait_stretch_a: assert property ((i_periph_wait_ready_n[*3] ##0 !o_periph_strobe_n)
        |=> !o_periph_strobe_n)
        else $error("Strobe ended early");
    bus_hold_a: assert property (!o_periph_strobe_n ##1 !o_periph_strobe_n |-> $stable(o_periph_dir_n)
        && (o_periph_dir_n || $stable(o_periph_data_bus_out)))
        else $error("Access moved in wait");
    write_launch_a: assert property (ext_wr |=> !o_periph_strobe_n && !o_periph_dir_n
        && o_periph_data_bus_out == $past(i_reg_wdata))
        else $error("Write not launched");
    read_launch_a: assert property (ext_rd |=> !o_periph_strobe_n && o_periph_dir_n)
        else $error("Read not launched");
    write_single_a: assert property (((!i_periph_wait_ready_n)[*2] ##0 ext_wr) ##1 !i_periph_wait_ready_n
        |=> o_periph_strobe_n)
        else $error("Write too long");
    halt_hold_a: assert property (i_halt[*3] |=> $stable(o_prog_addr_out))
        else $error("Address moved in halt");
    ext_write_c: cover property (ext_wr ##1 !o_periph_strobe_n);
    long_access_c: cover property ((!o_periph_strobe_n)[*4]);
    irq_entry_c: cover property (o_prog_addr_out == 16'h0FFF);
endmodule // dspx_core_pins_chk
bind dspx_core_pins dspx_core_pins_chk chk_i (.*);
`default_nettype wire

// [test/test_dspx_core_pins.sv]
// Bench for the DSP core pin-side sequencer
`timescale 1ns/1ps
`default_nettype none
module test_dspx_core_pins;
    import dspx_pkg::*;
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_halt = 1'b0;
    logic i_program_store_select_n = 1'b0;
    logic [3:0] i_reg_addr = 4'h0, wait_cycles = 4'h0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [2:0] i_irq_lines = 3'h0;
    logic [1:0] i_branch_test_inputs = 2'h0;
    logic [15:0] o_reg_rdata, o_periph_data_bus_out, i_periph_data_bus_in, o_prog_addr_out, i_prog_word_in, drv;
    logic [2:0] o_periph_reg_select;
    logic [1:0] o_general_outputs;
    logic o_periph_data_bus_oe, o_periph_dir_n, o_periph_strobe_n, i_periph_wait_ready_n, o_prog_addr_oe;
    int bad_count = 0, total_checks = 0;
    always #5 i_clock = ~i_clock;
    assign i_periph_data_bus_in = o_periph_data_bus_oe ? o_periph_data_bus_out : drv;
    dspx_core_pins #(.ROM_VEC_RESET(16'h0040), .ROM_VEC_IRQ0(16'h0100), .ROM_VEC_IRQ1(16'h0200),
        .ROM_VEC_IRQ2(16'h0300)) uut (.*);
    dspx_periph_model model (.i_clock(i_clock), .i_strobe_n(o_periph_strobe_n), .i_dir_n(o_periph_dir_n),
        .i_sel(o_periph_reg_select), .i_bus(o_periph_data_bus_out), .i_wait(wait_cycles),
        .o_ready_n(i_periph_wait_ready_n), .o_drive(drv), .i_prog_addr(o_prog_addr_out),
        .o_prog_word(i_prog_word_in));
    task automatic results;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic fail(input string what);
        bad_count++;
        $display("Error at %0t: %s timed out", $time, what);
        results();
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, exp);
    endtask
    task automatic done_wait;
        for (int k = 0; k < 40; k++) begin
            @(posedge i_clock);
            #1 if (o_periph_strobe_n === 1'b1) return;
        end
        fail("external access");
    endtask
    task automatic wait_addr(input logic [15:0] a);
        for (int k = 0; k < 40; k++) begin
            @(posedge i_clock);
            #1 if (o_prog_addr_out === a) return;
        end
        fail("program address");
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1 chk(o_prog_addr_out, 16'h0040);
        @(posedge i_clock) i_halt <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_halt <= 1'b0;
        i_branch_test_inputs <= 2'b10;
        wr(REG_STATUS, 16'h0020);
        repeat (2) @(posedge i_clock);
        #1 chk({14'h0000, o_general_outputs}, 16'h0002);
        rd(REG_STATUS, 16'h0820);
        wr(REG_BR_TARGET, 16'h0800);
        wr(REG_BR_TEST, 16'h0001);
        wait_addr(16'h0800);
        wr(REG_PTR, 16'h06FF);
        wr(REG_RAM_DATA, 16'h1234);
        wr(REG_PTR, 16'h06FF);
        rd(REG_RAM_DATA, 16'h1234);
        rd(REG_PTR, 16'h0000);
        wr(REG_PTR, 16'h0005);
        wr(REG_RAM_DATA, 16'h1111);
        wr(REG_PTR, 16'h0405);
        wr(REG_RAM_DATA, 16'h2222);
        wr(REG_PTR, 16'h0005);
        wr(REG_PTR, 16'h0405);
        wr(REG_MAC_X, 16'h0000);
        rd(REG_MAC_X, 16'h1111);
        rd(REG_MAC_Y, 16'h2222);
        rd(REG_PTR, 16'h0006);
        rd(4'hF, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wait_cycles <= i[0] ? 4'h2 : 4'h0;
            wr(REG_EXT_SEL, 16'(i));
            wr(REG_EXT_WRITE, 16'hA500 + 16'(i));
            done_wait();
            chk(model.regs[i], 16'hA500 + 16'(i));
        end
        wait_cycles <= 4'h3;
        for (int i = 0; i < 8; i++) begin
            wr(REG_EXT_SEL, 16'(i));
            wr(REG_EXT_READ, 16'h0000);
            wr(REG_EXT_SEL, 16'h0007);
            #1 chk({13'h0000, o_periph_reg_select}, 16'(i));
            done_wait();
            rd(REG_EXT_WRITE, 16'hA500 + 16'(i));
        end
        wr(REG_STATUS, 16'h0080);
        @(posedge i_clock) i_irq_lines <= 3'b101;
        wait_addr(16'h0FFF);
        wait_addr(16'h0FFD);
        @(posedge i_clock) i_irq_lines <= 3'b000;
        i_program_store_select_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_irq_lines <= 3'b010;
        wait_addr(16'hFFFE);
        wait_addr(16'h3000);
        results();
    end
endmodule // test_dspx_core_pins
`default_nettype wire
